// [design/isr_line_if.sv]
// Carrier for the sampled bus-line events passed from the pin sampler
// to the receive sequencer. All signals are in the core clock domain.
`timescale 1ns/1ps
`default_nettype none

interface isr_line_if;
  logic sclHigh;
  logic sclRise;
  logic sclFall;
  logic sdaHigh;
  logic startEvt;
  logic stopEvt;

  modport src (output sclHigh, sclRise, sclFall, sdaHigh, startEvt, stopEvt);
  modport dst (input  sclHigh, sclRise, sclFall, sdaHigh, startEvt, stopEvt);
endinterface

`default_nettype wire

// [design/isr_pin_sampler.sv]
// Two-flop synchronisers for the clock and data lines, plus edge,
// start and stop detection on the synchronised levels.
// Assumes the line clock is several core clocks long.
`timescale 1ns/1ps
`default_nettype none

module isr_pin_sampler (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Raw line levels
  input  wire logic sclIn,
  input  wire logic sdaIn,
  // Events toward the sequencer
  isr_line_if.src   lines
);

  logic [1:0] sclMeta_r;
  logic [1:0] sdaMeta_r;
  logic [1:0] sclMeta_nxt;
  logic [1:0] sdaMeta_nxt;
  logic       sclPrev_r;
  logic       sdaPrev_r;

  // Shift chains; lines idle high so reset to one
  always_comb
  begin
    sclMeta_nxt = {sclMeta_r[0], sclIn};
    sdaMeta_nxt = {sdaMeta_r[0], sdaIn};
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sclMeta_r <= 2'h3;
      sdaMeta_r <= 2'h3;
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end
    else
    begin
      sclMeta_r <= sclMeta_nxt;
      sdaMeta_r <= sdaMeta_nxt;
      sclPrev_r <= sclMeta_r[1];
      sdaPrev_r <= sdaMeta_r[1];
    end
  end

  // Edges only look at the second stage, never the first
  assign lines.sclHigh  = sclMeta_r[1];
  assign lines.sdaHigh  = sdaMeta_r[1];
  assign lines.sclRise  = sclMeta_r[1] & ~sclPrev_r;
  assign lines.sclFall  = ~sclMeta_r[1] & sclPrev_r;
  // Data moving while the clock stays high marks start or stop
  assign lines.startEvt = sclMeta_r[1] & sclPrev_r & ~sdaMeta_r[1] & sdaPrev_r;
  assign lines.stopEvt  = sclMeta_r[1] & sclPrev_r & sdaMeta_r[1] & ~sdaPrev_r;

endmodule // isr_pin_sampler

`default_nettype wire

// [design/isr_pkg.sv]
// Constants shared by the two-wire target receiver: register map, field
// positions, reset values, bus responses and the sequencer states.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package isr_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] IEN_OFS    = 8'h04;
  localparam logic [7:0] FLAG_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0C;
  localparam logic [7:0] MATCH0_OFS = 8'h10;
  localparam logic [7:0] MATCH3_OFS = 8'h1C;
  localparam logic [7:0] ADB_OFS    = 8'h20;
  localparam logic [7:0] RXB_OFS    = 8'h24;
  localparam logic [7:0] CNT_OFS    = 8'h28;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_STRETCH_BIT = 1;
  localparam int unsigned CTRL_ACK_VALUE_NORMAL_BIT   = 2;
  localparam int unsigned CTRL_ACK_VALUE_AT_COUNT_END_BIT  = 3;

  // Hold and interrupt enable fields
  localparam int unsigned IEN_START_BIT = 0;
  localparam int unsigned IEN_ADDR_BIT  = 1;
  localparam int unsigned IEN_DATA_BIT  = 2;
  localparam int unsigned IEN_ACK_BIT   = 3;

  // Event flag fields, write one to clear
  localparam int unsigned FLG_START_BIT = 0;
  localparam int unsigned FLG_STOP_BIT  = 1;
  localparam int unsigned FLG_ADDR_BIT  = 2;
  localparam int unsigned FLG_DATA_BIT  = 3;
  localparam int unsigned FLG_CNT_BIT   = 4;
  localparam int unsigned FLG_NACK_BIT  = 5;
  localparam int unsigned FLG_COMB_BIT  = 6;
  localparam int unsigned FLG_RX_BIT    = 7;

  // Status fields; only the overflow bit is writable (one to clear)
  localparam int unsigned STA_SMA_BIT  = 0;
  localparam int unsigned STA_DIR_BIT  = 1;
  localparam int unsigned STA_DA_BIT   = 2;
  localparam int unsigned STA_RX_BUFFER_FULL_BIT = 3;
  localparam int unsigned STA_RXOV_BIT = 4;

  // Reset values
  localparam logic [3:0] CTRL_RST  = 4'h0;
  localparam logic [3:0] IEN_RST   = 4'h0;
  localparam logic [7:0] FLAG_RST  = 8'h00;
  localparam logic [6:0] MATCH_RST = 7'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK
  } isr_state_t;

endpackage

// [design/isr_target_rx.sv]
// Two-wire bus target receiver, 7-bit addressing, with AXI4-Lite registers.
// Assumes an external open-drain pad; an output enable pulls the line low.
//
// Contract
// (RQ1) Eighth address bit is direction; copy it to status on match.
// (RQ2) Start or repeated start sets the start flag.
// (RQ3) Start with its enable set also sets the combined flag.
// (RQ4) Compare received 7-bit address with all four match registers.
// (RQ5) Match sets addressed bit, copies direction, clears data bit; else idle.
// (RQ6) Match loads address buffer and sets address-received flag.
// (RQ7) Address hold enable sets stretch bit and combined flag.
// (RQ8) Pending overflow error forces not-acknowledge, then idle.
// (RQ9) Normal acknowledge value goes out on the ninth address pulse.
// (RQ10) Acknowledge hold enable stretches clock until software clears stretch bit.
// (RQ11) Controller sends next byte clocks, or stop after not-acknowledge.
// (RQ12) Stop sets stop flag and returns to idle.
// (RQ13) Buffer still full before eighth pulse: stretch until buffer read.
// (RQ14) Eighth data pulse sets data bit and data-written flag.
// (RQ15) Byte lands in receive buffer; buffer-full and receive flag set.
// (RQ16) Data hold enable sets stretch bit and combined flag.
// (RQ17) Count zero selects end-of-count ack; else normal ack, count decrements.
// (RQ18) Selected data acknowledge goes out on the ninth pulse.
// (RQ19) Count zero sets count-reached flag.
// (RQ20) Sent not-acknowledge sets error flag and returns to idle.
// (RQ21) After data ack with hold, stretch and interrupt; buffer read clears full.
// (RQ22) Clock line held low while stretch bit set.
`timescale 1ns/1ps
`default_nettype none

module isr_target_rx (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial lines, open drain
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);

  // Mapped word check, shared by read and write paths
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= isr_pkg::CNT_OFS);
  endfunction

  isr_line_if lines ();

  isr_pin_sampler u_sampler (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .lines    (lines.src)
  );

  // ---------------- Bus slave state ----------------
  logic [7:0]  awAddr_r, awAddr_nxt;
  logic        awHave_r, awHave_nxt;
  logic [7:0]  wData_r, wData_nxt;
  logic        wLane_r, wLane_nxt;
  logic        wHave_r, wHave_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wrFire;
  logic        rdFire;
  logic [7:0]  readWord;

  // ---------------- Core state ----------------
  isr_pkg::isr_state_t state_r, state_nxt;
  logic [3:0]  ctrl_r, ctrl_nxt;
  logic [3:0]  ien_r, ien_nxt;
  logic [7:0]  flags_r, flags_nxt;
  logic        sma_r, sma_nxt;
  logic        dir_r, dir_nxt;
  logic        dataAddr_r, dataAddr_nxt;
  logic        rxFull_r, rxFull_nxt;
  logic        rxOver_r, rxOver_nxt;
  logic [6:0]  match_r [4];
  logic [6:0]  match_nxt [4];
  logic [7:0]  addrBuf_r, addrBuf_nxt;
  logic [7:0]  rxBuf_r, rxBuf_nxt;
  logic [7:0]  count_r, count_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [3:0]  bitCnt_r, bitCnt_nxt;
  logic        useCntAck_r, useCntAck_nxt;
  logic        forceNack_r, forceNack_nxt;
  logic        driving_r, driving_nxt;
  logic        ninthSeen_r, ninthSeen_nxt;
  logic        rxWait_r, rxWait_nxt;
  logic        holdLatch_r, holdLatch_nxt;
  logic        sclOe_r, sdaOe_r;
  logic        ackVal;
  logic        stretchOn;

  // Bus handshakes: each address and data taken once, in either order
  assign awready = ~awHave_r & ~bvalid_r;
  assign wready  = ~wHave_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;
  assign wrFire  = awHave_r & wHave_r & ~bvalid_r;
  assign rdFire  = arvalid & ~rvalid_r;

  // Read multiplexer over the register map
  always_comb
  begin
    readWord = 8'h00;
    case (araddr)
      isr_pkg::CTRL_OFS: readWord = {4'h0, ctrl_r};
      isr_pkg::IEN_OFS:  readWord = {4'h0, ien_r};
      isr_pkg::FLAG_OFS: readWord = flags_r;
      isr_pkg::STAT_OFS: readWord = {3'h0, rxOver_r, rxFull_r, dataAddr_r, dir_r, sma_r};
      isr_pkg::ADB_OFS:  readWord = addrBuf_r;
      isr_pkg::RXB_OFS:  readWord = rxBuf_r;
      isr_pkg::CNT_OFS:  readWord = count_r;
      default:
      begin
        if (araddr >= isr_pkg::MATCH0_OFS && araddr <= isr_pkg::MATCH3_OFS)
          readWord = {1'b0, match_r[araddr[3:2]]};
      end
    endcase
  end

  // Bus slave next values; unmapped words answer SLVERR
  always_comb
  begin
    awAddr_nxt = awAddr_r;
    awHave_nxt = awHave_r;
    wData_nxt  = wData_r;
    wLane_nxt  = wLane_r;
    wHave_nxt  = wHave_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (awvalid && awready)
    begin
      awAddr_nxt = awaddr;
      awHave_nxt = 1'b1;
    end
    if (wvalid && wready)
    begin
      wData_nxt = wdata[7:0];
      wLane_nxt = wstrb[0];
      wHave_nxt = 1'b1;
    end
    if (wrFire)
    begin
      awHave_nxt = 1'b0;
      wHave_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = isMapped(awAddr_r) ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
    end
    else if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
    if (rdFire)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, readWord};
      rresp_nxt  = isMapped(araddr) ? isr_pkg::RESP_OKAY : isr_pkg::RESP_SLVERR;
    end
    else if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      awAddr_r <= 8'h00;
      awHave_r <= 1'b0;
      wData_r  <= 8'h00;
      wLane_r  <= 1'b0;
      wHave_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= isr_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= isr_pkg::RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end
    else
    begin
      awAddr_r <= awAddr_nxt;
      awHave_r <= awHave_nxt;
      wData_r  <= wData_nxt;
      wLane_r  <= wLane_nxt;
      wHave_r  <= wHave_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Acknowledge level: one means not-acknowledge (line left released)
  assign ackVal = forceNack_r |
                  (useCntAck_r ? ctrl_r[isr_pkg::CTRL_ACK_VALUE_AT_COUNT_END_BIT]
                               : ctrl_r[isr_pkg::CTRL_ACK_VALUE_NORMAL_BIT]);
  assign stretchOn = ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT]; // Pulls a cycle sooner after a fall

  // Sequencer and register file next values. Software clears are applied
  // first so a hardware set in the same cycle wins.
  always_comb
  begin
    state_nxt     = state_r;
    ctrl_nxt      = ctrl_r;
    ien_nxt       = ien_r;
    flags_nxt     = flags_r;
    sma_nxt       = sma_r;
    dir_nxt       = dir_r;
    dataAddr_nxt  = dataAddr_r;
    rxFull_nxt    = rxFull_r;
    rxOver_nxt    = rxOver_r;
    match_nxt     = match_r;
    addrBuf_nxt   = addrBuf_r;
    rxBuf_nxt     = rxBuf_r;
    count_nxt     = count_r;
    shift_nxt     = shift_r;
    bitCnt_nxt    = bitCnt_r;
    useCntAck_nxt = useCntAck_r;
    forceNack_nxt = forceNack_r;
    driving_nxt   = driving_r;
    ninthSeen_nxt = ninthSeen_r;
    rxWait_nxt    = rxWait_r;
    // Software writes
    if (wrFire && wLane_r && isMapped(awAddr_r))
    begin
      case (awAddr_r)
        isr_pkg::CTRL_OFS: ctrl_nxt = wData_r[3:0];
        isr_pkg::IEN_OFS:  ien_nxt = wData_r[3:0];
        isr_pkg::FLAG_OFS: flags_nxt = flags_r & ~wData_r;
        isr_pkg::STAT_OFS: rxOver_nxt = rxOver_r & ~wData_r[isr_pkg::STA_RXOV_BIT];
        isr_pkg::CNT_OFS:  count_nxt = wData_r;
        default:
        begin
          if (awAddr_r >= isr_pkg::MATCH0_OFS && awAddr_r <= isr_pkg::MATCH3_OFS)
            match_nxt[awAddr_r[3:2]] = wData_r[6:0];
        end
      endcase
    end
    // (RQ21) buffer read empties
    if (rdFire && araddr == isr_pkg::RXB_OFS)
    begin
      rxFull_nxt = 1'b0;
      // (RQ13) read releases stall
      if (rxWait_r)
      begin
        rxWait_nxt = 1'b0;
        ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT] = 1'b0;
      end
    end
    // Line events; a disabled block ignores the bus
    if (!ctrl_r[isr_pkg::CTRL_EN_BIT])
      state_nxt = isr_pkg::ST_IDLE;
    else if (lines.startEvt)
    begin
      // (RQ2) start seen
      flags_nxt[isr_pkg::FLG_START_BIT] = 1'b1;
      // (RQ3) combined on start
      if (ien_r[isr_pkg::IEN_START_BIT])
        flags_nxt[isr_pkg::FLG_COMB_BIT] = 1'b1;
      state_nxt  = isr_pkg::ST_ADDR;
      bitCnt_nxt = 4'h0;
    end
    else if (lines.stopEvt)
    begin
      // (RQ12) stop, back to idle
      flags_nxt[isr_pkg::FLG_STOP_BIT] = 1'b1;
      sma_nxt   = 1'b0;
      state_nxt = isr_pkg::ST_IDLE;
    end
    else
    begin
      case (state_r)
        isr_pkg::ST_ADDR,
        isr_pkg::ST_DATA:
        begin
          // (RQ13) stall before eighth pulse
          if (state_r == isr_pkg::ST_DATA && lines.sclFall && bitCnt_r == 4'h7 && rxFull_r)
          begin
            ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT] = 1'b1;
            rxWait_nxt = 1'b1;
          end
          if (lines.sclRise)
          begin
            shift_nxt  = {shift_r[6:0], lines.sdaHigh};
            bitCnt_nxt = bitCnt_r + 4'h1;
            driving_nxt   = 1'b0;
            ninthSeen_nxt = 1'b0;
            if (bitCnt_r == 4'h7 && state_r == isr_pkg::ST_ADDR)
            begin
              // (RQ4) compare against four match values
              if ((shift_r[6:0] == match_r[0]) || (shift_r[6:0] == match_r[1]) ||
                  (shift_r[6:0] == match_r[2]) || (shift_r[6:0] == match_r[3]))
              begin
                // (RQ5) addressed, data bit cleared
                sma_nxt      = 1'b1;
                dataAddr_nxt = 1'b0;
                // (RQ1) last bit is direction
                dir_nxt = lines.sdaHigh;
                // (RQ6) address buffered
                addrBuf_nxt = {shift_r[6:0], lines.sdaHigh};
                flags_nxt[isr_pkg::FLG_ADDR_BIT] = 1'b1;
                // (RQ7) address hold
                if (ien_r[isr_pkg::IEN_ADDR_BIT])
                begin
                  ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT] = 1'b1;
                  flags_nxt[isr_pkg::FLG_COMB_BIT] = 1'b1;
                end
                // (RQ8) pending error forces not-acknowledge
                forceNack_nxt = rxOver_r;
                useCntAck_nxt = 1'b0;
                state_nxt     = isr_pkg::ST_ADDR_ACK;
              end
              else
                // (RQ5) mismatch
                state_nxt = isr_pkg::ST_IDLE;
            end
            else if (bitCnt_r == 4'h7)
            begin
              // (RQ14) eighth data pulse
              dataAddr_nxt = 1'b1;
              flags_nxt[isr_pkg::FLG_DATA_BIT] = 1'b1;
              // (RQ15) byte into buffer
              rxBuf_nxt  = {shift_r[6:0], lines.sdaHigh};
              rxOver_nxt = rxOver_nxt | rxFull_nxt;
              rxFull_nxt = 1'b1;
              flags_nxt[isr_pkg::FLG_RX_BIT] = 1'b1;
              // (RQ16) data hold
              if (ien_r[isr_pkg::IEN_DATA_BIT])
              begin
                ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT] = 1'b1;
                flags_nxt[isr_pkg::FLG_COMB_BIT] = 1'b1;
              end
              // (RQ17) select acknowledge source
              useCntAck_nxt = (count_nxt == 8'h00);
              forceNack_nxt = 1'b0;
              if (count_nxt == 8'h00)
                // (RQ19) count reached
                flags_nxt[isr_pkg::FLG_CNT_BIT] = 1'b1;
              else
                count_nxt = count_nxt - 8'h01;
              state_nxt = isr_pkg::ST_DATA_ACK;
            end
          end
        end
        isr_pkg::ST_ADDR_ACK,
        isr_pkg::ST_DATA_ACK:
        begin
          // (RQ9) drive from fall after eighth pulse
          if (lines.sclFall && !driving_r)
            driving_nxt = 1'b1;
          else if (lines.sclRise && driving_r)
            ninthSeen_nxt = 1'b1;
          else if (lines.sclFall && ninthSeen_r)
          begin
            driving_nxt = 1'b0;
            bitCnt_nxt  = 4'h0;
            if (ackVal)
            begin
              // (RQ20) not-acknowledge sent
              if (state_r == isr_pkg::ST_DATA_ACK)
                flags_nxt[isr_pkg::FLG_NACK_BIT] = 1'b1;
              state_nxt = isr_pkg::ST_IDLE;
            end
            else
            begin
              // (RQ10) hold after acknowledge
              if (ien_r[isr_pkg::IEN_ACK_BIT])
              begin
                ctrl_nxt[isr_pkg::CTRL_STRETCH_BIT] = 1'b1;
                flags_nxt[isr_pkg::FLG_COMB_BIT] = 1'b1;
              end
              // Controller reads are not served here
              state_nxt = dir_r ? isr_pkg::ST_IDLE : isr_pkg::ST_DATA;
            end
          end
        end
        default:
          state_nxt = isr_pkg::ST_IDLE;
      endcase
    end
  end

  // (RQ22) pull clock only once it is seen low, so no early edge is made
  always_comb
  begin
    holdLatch_nxt = stretchOn & (holdLatch_r | ~lines.sclHigh);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r     <= isr_pkg::ST_IDLE;
      ctrl_r      <= isr_pkg::CTRL_RST;
      ien_r       <= isr_pkg::IEN_RST;
      flags_r     <= isr_pkg::FLAG_RST;
      sma_r       <= 1'b0;
      dir_r       <= 1'b0;
      dataAddr_r  <= 1'b0;
      rxFull_r    <= 1'b0;
      rxOver_r    <= 1'b0;
      for (int i = 0; i < 4; i++)
        match_r[i] <= isr_pkg::MATCH_RST;
      addrBuf_r   <= 8'h00;
      rxBuf_r     <= 8'h00;
      count_r     <= isr_pkg::CNT_RST;
      shift_r     <= 8'h00;
      bitCnt_r    <= 4'h0;
      useCntAck_r <= 1'b0;
      forceNack_r <= 1'b0;
      driving_r   <= 1'b0;
      ninthSeen_r <= 1'b0;
      rxWait_r    <= 1'b0;
      holdLatch_r <= 1'b0;
      sclOe_r     <= 1'b0;
      sdaOe_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      ctrl_r      <= ctrl_nxt;
      ien_r       <= ien_nxt;
      flags_r     <= flags_nxt;
      sma_r       <= sma_nxt;
      dir_r       <= dir_nxt;
      dataAddr_r  <= dataAddr_nxt;
      rxFull_r    <= rxFull_nxt;
      rxOver_r    <= rxOver_nxt;
      match_r     <= match_nxt;
      addrBuf_r   <= addrBuf_nxt;
      rxBuf_r     <= rxBuf_nxt;
      count_r     <= count_nxt;
      shift_r     <= shift_nxt;
      bitCnt_r    <= bitCnt_nxt;
      useCntAck_r <= useCntAck_nxt;
      forceNack_r <= forceNack_nxt;
      driving_r   <= driving_nxt;
      ninthSeen_r <= ninthSeen_nxt;
      rxWait_r    <= rxWait_nxt;
      holdLatch_r <= holdLatch_nxt;
      sclOe_r     <= holdLatch_nxt;
      // (RQ18) acknowledge low drives the data line
      sdaOe_r     <= driving_nxt & ~ackVal;
    end
  end

  // Open-drain pads only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = sclOe_r;
  assign sdaOe  = sdaOe_r;

endmodule // isr_target_rx

`default_nettype wire

// [tb/isr_bus_ctl.sv]
// Two-wire bus controller model on open-drain pull-downs.
// Assumes pulled-up wires; waits out stretching, bounded.
`timescale 1ns/1ps
`default_nettype none

module isr_bus_ctl (
  // Wire levels
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Pull-downs, high pulls low
  output logic      sclLow,
  output logic      sdaLow
);
  localparam time HalfT = 400;
  logic hung = 1'b0;
  initial {sclLow, sdaLow} = 2'h0;
  // Release clock, wait out stretch
  task automatic rise_scl();
    int n = 0;
    sclLow <= 1'b0;
    while (!sclLine && n < 4000)
    begin
      #50;
      n++;
    end
    if (n >= 4000) hung = 1'b1;
    #HalfT;
  endtask
  // Data moves while the clock is low
  task automatic put_bit(input logic b, output logic s);
    sdaLow <= !b;
    #HalfT;
    rise_scl();
    s = sdaLine;
    sclLow <= 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  // Start or restart
  task automatic start();
    sdaLow <= 1'b0;
    #HalfT;
    rise_scl();
    sdaLow <= 1'b1;
    #HalfT;
    sclLow <= 1'b1;
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    #HalfT;
    rise_scl();
    sdaLow <= 1'b0;
    #HalfT;
  endtask
endmodule // isr_bus_ctl

`default_nettype wire

// [tb/isr_checker.sv]
// Port assertions for the target receiver.
// Assumes one core_clk domain; bound below.
`timescale 1ns/1ps
`default_nettype none

module isr_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Serial lines
  input wire logic        sclIn,
  input wire logic        sclOe,
  input wire logic        sdaOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Answers stand until taken
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("response dropped");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_r_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_w_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken in response");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read taken in response");
  chk_r_cause: assert property ($rose(rvalid) |-> $past(arvalid && arready))
    else $error("read answer unasked");
  // Drive starts only while the clock is low
  chk_ack_low: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("ack in high phase");
  chk_stretch_low: assert property ($rose(sclOe) |-> !sclIn)
    else $error("stretch in high phase");
  cover property ($rose(sclOe));
  cover property ($rose(sdaOe));
  cover property (bvalid && bready);
endmodule // isr_checker

bind isr_target_rx isr_checker chk (.*);
`default_nettype wire

// [tb/isr_target_rx_test.sv]
// Self-checking target receiver bench.
// Assumes the controller model on the wires.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end

module isr_target_rx_test;
  logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sclOe, sdaOe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  wire         sclLow, sdaLow;
  wire         sclIn = !(sclLow || sclOe);
  wire         sdaIn = !(sdaLow || sdaOe);
  int          fails = 0, checks = 0;

  isr_target_rx dut (.*, .sclOut(), .sdaOut());
  isr_bus_ctl mdl (.sclLine(sclIn), .sdaLine(sdaIn), .sclLow(sclLow), .sdaLow(sdaLow));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang();
    fails++;
    end_sim();
  endtask
  // Bus write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 40);
    bready <= 1'b0;
    `CHK(bresp, isr_pkg::RESP_OKAY)
    if (n >= 40) hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 40);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 40) hang();
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, {24'h0, e})
  endtask
  // Bounded wait for a clock hold
  task automatic wait_hold();
    int n = 0;
    while (!sclOe && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) hang();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc(isr_pkg::CTRL_OFS, 8'h00);
    rc(isr_pkg::FLAG_OFS, 8'h00);
    rd(8'h2C, d, r);
    `CHK(r, isr_pkg::RESP_SLVERR)
  endtask
  // Write with count-based acknowledge
  task automatic t_rx();
    logic k;
    wr(isr_pkg::IEN_OFS, 32'h1);
    wr(isr_pkg::MATCH3_OFS, 32'h2A);
    wr(isr_pkg::CNT_OFS, 32'h1);
    wr(isr_pkg::CTRL_OFS, 32'h9);
    mdl.start();
    mdl.send(8'h54, k);
    `CHK(k, 1'b1)
    rc(isr_pkg::FLAG_OFS, 8'h45);
    rc(isr_pkg::STAT_OFS, 8'h01);
    rc(isr_pkg::ADB_OFS, 8'h54);
    mdl.send(8'hA5, k);
    `CHK(k, 1'b1)
    rc(isr_pkg::STAT_OFS, 8'h0D);
    rc(isr_pkg::FLAG_OFS, 8'hCD);
    rc(isr_pkg::CNT_OFS, 8'h00);
    rc(isr_pkg::RXB_OFS, 8'hA5);
    mdl.send(8'h3C, k);
    `CHK(k, 1'b0)
    mdl.stop();
    rc(isr_pkg::FLAG_OFS, 8'hFF);
    rc(isr_pkg::RXB_OFS, 8'h3C);
  endtask
  // Foreign address, then a read on restart
  task automatic t_miss();
    logic k;
    mdl.start();
    mdl.send(8'h23, k);
    `CHK(k, 1'b0)
    mdl.start();
    mdl.send(8'h55, k);
    `CHK(k, 1'b1)
    rc(isr_pkg::STAT_OFS, 8'h03);
    mdl.stop();
  endtask
  // Address hold, data hold, full-buffer stall
  task automatic t_hold();
    logic k;
    wr(isr_pkg::CNT_OFS, 32'h5);
    wr(isr_pkg::IEN_OFS, 32'h2);
    mdl.start();
    fork
      mdl.send(8'h54, k);
      begin
        wait_hold();
        rc(isr_pkg::CTRL_OFS, 8'h0B);
        wr(isr_pkg::CTRL_OFS, 32'h9);
      end
    join
    wr(isr_pkg::FLAG_OFS, 32'hFF);
    wr(isr_pkg::IEN_OFS, 32'h4);
    fork
      mdl.send(8'h77, k);
      begin
        wait_hold();
        rc(isr_pkg::FLAG_OFS, 8'hC8);
        wr(isr_pkg::CTRL_OFS, 32'h9);
      end
    join
    wr(isr_pkg::IEN_OFS, 32'h0);
    fork
      mdl.send(8'h12, k);
      begin
        wait_hold();
        rc(isr_pkg::RXB_OFS, 8'h77);
      end
    join
    `CHK(k, 1'b1)
    rc(isr_pkg::RXB_OFS, 8'h12);
    mdl.stop();
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_rx();
    t_miss();
    t_hold();
    `CHK(mdl.hung, 1'b0)
    end_sim();
  end
endmodule // isr_target_rx_test

`default_nettype wire
